//--- hw/fes_ctrl.sv
// erase, erase-status and suspend/resume sequencer of the serial flash core
`timescale 1ns/1ps
module fes_ctrl #(
   parameter int CNT_W = 20,
   parameter int PROG_CYC = 256,
   parameter int SERASE_CYC = 1024,
   parameter int CERASE_CYC = 4096,
   parameter int EVAL_CYC = 64,
   parameter int SUSP_CYC = 32,
   parameter int NSECT = 64,
   parameter int SECT_LSB = 17,
   parameter int PAGE_LSB = 9
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // serial link pins
   input wire logic csn_i,
   input wire logic sck_i,
   input wire logic si_i,
   // read path address check
   input wire logic [31:0] rd_addr_i,
   output logic rd_undefined_o,
   // status and array control
   output logic [7:0] status_one_o,
   output logic [7:0] status_two_o,
   output logic array_fill_ones_o
);
   localparam int IDX_W = $clog2(NSECT);

   // link synchronisers and frame receiver
   logic csn_s1_reg, csn_s2_reg, csn_s3_reg, sck_s1_reg, sck_s2_reg, sck_s3_reg, si_s1_reg, si_s2_reg;
   logic cmd_v_reg, cmd_v_next;
   logic [5:0] nbits_reg, nbits_next;
   logic [7:0] opc_reg, opc_next;
   logic [31:0] addr_reg, addr_next;
   logic [7:0] data_reg, data_next;
   always_comb begin
      nbits_next = nbits_reg;
      opc_next = opc_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      cmd_v_next = csn_s2_reg & ~csn_s3_reg;
      if (!csn_s2_reg && csn_s3_reg) begin
         nbits_next = 6'h0;
      end else if (!csn_s2_reg && sck_s2_reg && !sck_s3_reg) begin
         if (nbits_reg < fes_pkg::BITS_OPCODE) begin
            opc_next = {opc_reg[6:0], si_s2_reg};
         end else if (nbits_reg < fes_pkg::BITS_ADDR) begin
            addr_next = {addr_reg[30:0], si_s2_reg};
         end else if (nbits_reg < fes_pkg::BITS_DATA) begin
            data_next = {data_reg[6:0], si_s2_reg};
         end
         if (nbits_reg != fes_pkg::BITS_MAX) begin
            nbits_next = nbits_reg + 6'h1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         csn_s1_reg <= 1'b1;
         csn_s2_reg <= 1'b1;
         csn_s3_reg <= 1'b1;
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sck_s3_reg <= 1'b0;
         si_s1_reg <= 1'b0;
         si_s2_reg <= 1'b0;
         nbits_reg <= 6'h0;
         opc_reg <= 8'h0;
         addr_reg <= fes_pkg::ADDR_RESET;
         data_reg <= 8'h0;
         cmd_v_reg <= 1'b0;
      end else begin
         csn_s1_reg <= csn_i;
         csn_s2_reg <= csn_s1_reg;
         csn_s3_reg <= csn_s2_reg;
         sck_s1_reg <= sck_i;
         sck_s2_reg <= sck_s1_reg;
         sck_s3_reg <= sck_s2_reg;
         si_s1_reg <= si_i;
         si_s2_reg <= si_s1_reg;
         nbits_reg <= nbits_next;
         opc_reg <= opc_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         cmd_v_reg <= cmd_v_next;
      end
   end
   // command decode
   wire has_addr = nbits_reg >= fes_pkg::BITS_ADDR;
   wire has_data = nbits_reg >= fes_pkg::BITS_DATA;
   wire is_susp = opc_reg == fes_pkg::OPC_SUSPEND_A || opc_reg == fes_pkg::OPC_SUSPEND_B;
   wire is_resume = opc_reg == fes_pkg::OPC_RESUME_A || opc_reg == fes_pkg::OPC_RESUME_B;
   wire is_erase = opc_reg == fes_pkg::OPC_WHOLE_ARRAY_ERASE || opc_reg == fes_pkg::OPC_SECTOR_ERASE;
   // sequencer state
   fes_pkg::fes_op_e op_reg, op_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next, prem_reg, prem_next, erem_reg, erem_next;
   logic stopping_reg, stopping_next, psus_reg, psus_next, esus_reg, esus_next;
   logic pone_reg, pone_next, eone_reg, eone_next, fill_reg, fill_next, undef_reg, undef_next;
   logic wel_reg, wel_next, efail_reg, efail_next, estat_reg, estat_next;
   logic [31:0] paddr_reg, paddr_next, eaddr_reg, eaddr_next, vaddr_reg, vaddr_next;
   logic [2:0] bp_reg, bp_next;
   logic [NSECT-1:0] done_reg, done_next;
   logic [7:0] st1_reg, st1_next, st2_reg, st2_next;
   wire [IDX_W-1:0] cmd_idx = addr_reg[SECT_LSB +: IDX_W];
   wire [IDX_W-1:0] eval_idx = vaddr_reg[SECT_LSB +: IDX_W];
   wire [IDX_W-1:0] erase_idx = eaddr_reg[SECT_LSB +: IDX_W];
   wire eval_hit = done_reg[eval_idx];
   wire idle = op_reg == fes_pkg::OP_IDLE;
   always_comb begin
      op_next = op_reg;
      cnt_next = cnt_reg;
      prem_next = prem_reg;
      erem_next = erem_reg;
      stopping_next = stopping_reg;
      psus_next = psus_reg;
      esus_next = esus_reg;
      pone_next = pone_reg;
      eone_next = eone_reg;
      paddr_next = paddr_reg;
      eaddr_next = eaddr_reg;
      vaddr_next = vaddr_reg;
      wel_next = wel_reg;
      efail_next = efail_reg;
      estat_next = estat_reg;
      bp_next = bp_reg;
      done_next = done_reg;
      fill_next = 1'b0;
      if (!idle && cnt_reg != '0) begin
         cnt_next = cnt_reg - CNT_W'(1);
         // a single suspend per running program or sector erase
         if (cmd_v_reg && is_susp && !stopping_reg) begin
            if (op_reg == fes_pkg::OP_PROG && !pone_reg) begin
               stopping_next = 1'b1;
               pone_next = 1'b1;
               prem_next = cnt_reg;
               cnt_next = CNT_W'(SUSP_CYC - 1);
            end else if (op_reg == fes_pkg::OP_SERASE && !eone_reg) begin
               stopping_next = 1'b1;
               eone_next = 1'b1;
               erem_next = cnt_reg;
               cnt_next = CNT_W'(SUSP_CYC - 1);
            end
         end
      end else if (!idle) begin
         op_next = fes_pkg::OP_IDLE;
         stopping_next = 1'b0;
         if (stopping_reg) begin
            // flags appear as busy falls
            if (op_reg == fes_pkg::OP_PROG) begin
               psus_next = 1'b1;
            end else begin
               esus_next = 1'b1;
            end
         end else begin
            unique case (op_reg)
               fes_pkg::OP_PROG: wel_next = 1'b0;
               fes_pkg::OP_SERASE: begin
                  wel_next = 1'b0;
                  done_next[erase_idx] = 1'b1;
               end
               fes_pkg::OP_CERASE: begin
                  wel_next = 1'b0;
                  done_next = '1;
                  fill_next = 1'b1;
               end
               fes_pkg::OP_EVAL: estat_next = eval_hit;
               fes_pkg::OP_IDLE: ;
            endcase
         end
      end else if (cmd_v_reg) begin
         unique case (opc_reg)
            fes_pkg::OPC_WRITE_ENABLE, fes_pkg::OPC_VOLATILE_WREN: begin
               if (!psus_reg) wel_next = 1'b1;
            end
            fes_pkg::OPC_WRITE_DISABLE: begin
               if (!psus_reg) wel_next = 1'b0;
            end
            fes_pkg::OPC_CLEAR_FAIL_FLAGS: efail_next = 1'b0;
            fes_pkg::OPC_GENERIC_REG_WRITE: begin
               if (has_data && wel_reg && !psus_reg && !esus_reg) begin
                  bp_next = data_reg[fes_pkg::BP_DATA_LSB +: 3];
                  wel_next = 1'b0;
               end
            end
            fes_pkg::OPC_WHOLE_ARRAY_ERASE: begin
               if (wel_reg && !psus_reg && !esus_reg) begin
                  wel_next = 1'b0;
                  if (bp_reg == 3'h0) begin
                     op_next = fes_pkg::OP_CERASE;
                     cnt_next = CNT_W'(CERASE_CYC - 1);
                  end
               end
            end
            fes_pkg::OPC_SECTOR_ERASE: begin
               if (has_addr && wel_reg && !psus_reg && !esus_reg) begin
                  wel_next = 1'b0;
                  if (bp_reg != 3'h0) begin
                     efail_next = 1'b1;
                  end else begin
                     op_next = fes_pkg::OP_SERASE;
                     cnt_next = CNT_W'(SERASE_CYC - 1);
                     eaddr_next = addr_reg;
                     eone_next = 1'b0;
                     done_next[cmd_idx] = 1'b0;
                  end
               end
            end
            fes_pkg::OPC_PAGE_PROGRAM: begin
               // other sectors only while an erase is suspended
               if (has_data && wel_reg && !psus_reg && !(esus_reg && cmd_idx == erase_idx)) begin
                  op_next = fes_pkg::OP_PROG;
                  cnt_next = CNT_W'(PROG_CYC - 1);
                  paddr_next = addr_reg;
                  pone_next = 1'b0;
               end
            end
            fes_pkg::OPC_ERASE_STATUS_EVAL: begin
               if (has_addr) begin
                  op_next = fes_pkg::OP_EVAL;
                  cnt_next = CNT_W'(EVAL_CYC - 1);
                  vaddr_next = addr_reg;
               end
            end
            fes_pkg::OPC_RESUME_A, fes_pkg::OPC_RESUME_B: begin
               if (psus_reg) begin
                  op_next = fes_pkg::OP_PROG;
                  cnt_next = prem_reg;
                  psus_next = 1'b0;
               end else if (esus_reg) begin
                  op_next = fes_pkg::OP_SERASE;
                  cnt_next = erem_reg;
                  esus_next = 1'b0;
               end
            end
            fes_pkg::OPC_SOFTWARE_RESET: begin
               psus_next = 1'b0;
               esus_next = 1'b0;
               wel_next = 1'b0;
               efail_next = 1'b0;
            end
            default: ;
         endcase
      end
      st1_next = 8'h0;
      st1_next[fes_pkg::ST1_BUSY] = op_next != fes_pkg::OP_IDLE;
      st1_next[fes_pkg::ST1_WEL] = wel_next;
      st1_next[fes_pkg::ST1_BP_LSB +: 3] = bp_next;
      st1_next[fes_pkg::ST1_EFAIL] = efail_next;
      st2_next = 8'h0;
      st2_next[fes_pkg::ST2_PROG_SUSP] = psus_next;
      st2_next[fes_pkg::ST2_ERASE_SUSP] = esus_next;
      st2_next[fes_pkg::ST2_ERASE_OK] = estat_next;
      undef_next = (psus_reg && rd_addr_i[31:PAGE_LSB] == paddr_reg[31:PAGE_LSB])
         || (esus_reg && rd_addr_i[31:SECT_LSB] == eaddr_reg[31:SECT_LSB]);
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         op_reg <= fes_pkg::OP_IDLE;
         cnt_reg <= '0;
         prem_reg <= '0;
         erem_reg <= '0;
         stopping_reg <= 1'b0;
         psus_reg <= 1'b0;
         esus_reg <= 1'b0;
         pone_reg <= 1'b0;
         eone_reg <= 1'b0;
         paddr_reg <= fes_pkg::ADDR_RESET;
         eaddr_reg <= fes_pkg::ADDR_RESET;
         vaddr_reg <= fes_pkg::ADDR_RESET;
         wel_reg <= 1'b0;
         efail_reg <= 1'b0;
         estat_reg <= 1'b0;
         bp_reg <= fes_pkg::BP_RESET;
         done_reg <= '0;
         fill_reg <= 1'b0;
         undef_reg <= 1'b0;
         st1_reg <= 8'h0;
         st2_reg <= 8'h0;
      end else begin
         op_reg <= op_next;
         cnt_reg <= cnt_next;
         prem_reg <= prem_next;
         erem_reg <= erem_next;
         stopping_reg <= stopping_next;
         psus_reg <= psus_next;
         esus_reg <= esus_next;
         pone_reg <= pone_next;
         eone_reg <= eone_next;
         paddr_reg <= paddr_next;
         eaddr_reg <= eaddr_next;
         vaddr_reg <= vaddr_next;
         wel_reg <= wel_next;
         efail_reg <= efail_next;
         estat_reg <= estat_next;
         bp_reg <= bp_next;
         done_reg <= done_next;
         fill_reg <= fill_next;
         undef_reg <= undef_next;
         st1_reg <= st1_next;
         st2_reg <= st2_next;
      end
   end
   assign status_one_o = st1_reg;
   assign status_two_o = st2_reg;
   assign array_fill_ones_o = fill_reg;
   assign rd_undefined_o = undef_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   wire op_done = !idle && cnt_reg == '0;
   a_chip_fill_all: assert property (op_done && !stopping_reg && op_reg == fes_pkg::OP_CERASE
      |=> fill_reg && &done_reg) else $error("whole array erase did not fill ones");
   a_protect_discard: assert property (cmd_v_reg && idle && opc_reg == fes_pkg::OPC_WHOLE_ARRAY_ERASE
      && bp_reg != 3'h0 |=> idle && $stable(efail_reg)) else $error("protected array erase ran");
   a_eval_result: assert property (op_done && op_reg == fes_pkg::OP_EVAL
      |=> status_two_o[fes_pkg::ST2_ERASE_OK] == $past(eval_hit)) else $error("evaluation result wrong");
   a_eval_no_latch: assert property (cmd_v_reg && idle && !wel_reg && has_addr
      && opc_reg == fes_pkg::OPC_ERASE_STATUS_EVAL |=> op_reg == fes_pkg::OP_EVAL) else $error("eval not started");
   a_eval_busy: assert property ($rose(op_reg == fes_pkg::OP_EVAL) |-> status_one_o[fes_pkg::ST1_BUSY]
      ##1 status_one_o[fes_pkg::ST1_BUSY] ##1 status_one_o[fes_pkg::ST1_BUSY]) else $error("busy low in eval");
   a_eval_time: assert property ($rose(op_reg == fes_pkg::OP_EVAL) |-> cnt_reg == CNT_W'(EVAL_CYC - 1))
      else $error("evaluation time wrong");
   a_one_suspend: assert property (cmd_v_reg && is_susp && op_reg == fes_pkg::OP_PROG && pone_reg
      && !stopping_reg |=> !stopping_reg) else $error("second suspend accepted");
   a_suspend_latency: assert property ($rose(stopping_reg) |-> ##[1:64] !stopping_reg && idle)
      else $error("suspend latency exceeded");
   a_prog_flag: assert property (op_done && stopping_reg && op_reg == fes_pkg::OP_PROG
      |=> status_two_o[fes_pkg::ST2_PROG_SUSP] && !status_one_o[fes_pkg::ST1_BUSY]) else $error("no prog flag");
   a_no_chip_susp: assert property (op_reg == fes_pkg::OP_CERASE |-> !stopping_reg)
      else $error("array erase suspended");
   a_erase_flag: assert property (op_done && stopping_reg && op_reg == fes_pkg::OP_SERASE
      |=> status_two_o[fes_pkg::ST2_ERASE_SUSP]) else $error("no erase suspend flag");
   a_read_undef: assert property (psus_reg && rd_addr_i[31:PAGE_LSB] == paddr_reg[31:PAGE_LSB]
      |=> rd_undefined_o) else $error("suspended page read marked valid");
   a_erase_ignored: assert property (cmd_v_reg && idle && is_erase && (psus_reg || esus_reg)
      |=> idle) else $error("erase accepted while suspended");
   a_bp_frozen: assert property ((psus_reg || esus_reg) && idle |=> $stable(bp_reg))
      else $error("protection changed while suspended");
   a_resume_prog: assert property (cmd_v_reg && idle && is_resume && psus_reg && esus_reg
      |=> op_reg == fes_pkg::OP_PROG && esus_reg) else $error("resume order wrong");
   a_idle_suspend: assert property (cmd_v_reg && idle && is_susp |=> $stable({psus_reg, esus_reg}))
      else $error("idle suspend changed flags");
endmodule

//--- hw/fes_pkg.sv
// constants and types shared by the erase and suspend controller
package fes_pkg;
   // opcode values are arbitrary defaults
   localparam logic [7:0] OPC_WRITE_ENABLE = 8'h01;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h02;
   localparam logic [7:0] OPC_VOLATILE_WREN = 8'h03;
   localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h04;
   localparam logic [7:0] OPC_SECTOR_ERASE = 8'h05;
   localparam logic [7:0] OPC_WHOLE_ARRAY_ERASE = 8'h06;
   localparam logic [7:0] OPC_ERASE_STATUS_EVAL = 8'h07;
   localparam logic [7:0] OPC_SUSPEND_A = 8'h08;
   localparam logic [7:0] OPC_SUSPEND_B = 8'h09;
   localparam logic [7:0] OPC_RESUME_A = 8'h0a;
   localparam logic [7:0] OPC_RESUME_B = 8'h0b;
   localparam logic [7:0] OPC_SOFTWARE_RESET = 8'h0c;
   localparam logic [7:0] OPC_CLEAR_FAIL_FLAGS = 8'h0d;
   localparam logic [7:0] OPC_GENERIC_REG_WRITE = 8'h0e;

   // frame lengths and bit counter ceiling in link clock edges
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR = 6'h28;
   localparam logic [5:0] BITS_DATA = 6'h30;
   localparam logic [5:0] BITS_MAX = 6'h3f;

   // status register one fields
   localparam int ST1_BUSY = 0;
   localparam int ST1_WEL = 1;
   localparam int ST1_BP_LSB = 2;
   localparam int ST1_EFAIL = 5;
   // status register two fields
   localparam int ST2_PROG_SUSP = 0;
   localparam int ST2_ERASE_SUSP = 1;
   localparam int ST2_ERASE_OK = 2;
   // protection bits within the register write data byte
   localparam int BP_DATA_LSB = 2;

   localparam logic [2:0] BP_RESET = 3'h0;
   localparam logic [31:0] ADDR_RESET = 32'h0;

   typedef enum logic [2:0] {
      OP_IDLE,
      OP_PROG,
      OP_SERASE,
      OP_CERASE,
      OP_EVAL
   } fes_op_e;
endpackage

//--- verification/fes_host.sv
// serial host model that issues command frames on the link
`timescale 1ns/1ps
module fes_host #(
   // wait before a reset in suspend, plain default
   parameter int PEDS_CYC = 40
) (
   // system clock for frame alignment
   input wire logic clk_i,
   // link pins
   output logic csn_o,
   output logic sck_o,
   output logic si_o
);
   initial begin
      csn_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   // msb first, link clock still between frames, si toggled once released
   task automatic send(input logic [7:0] op, input logic [31:0] addr, input logic [7:0] data, input int nbits);
      logic [47:0] sh;
      sh = {op, addr, data};
      @(posedge clk_i);
      #1 csn_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si_o = sh[47 - i];
         #32 sck_o = 1'b1;
         #32 sck_o = 1'b0;
      end
      #32 csn_o = 1'b1;
      si_o = ~si_o;
      repeat (8) @(posedge clk_i);
      #1;
   endtask

   task automatic reset_after_wait();
      repeat (PEDS_CYC) @(posedge clk_i);
      send(fes_pkg::OPC_SOFTWARE_RESET, 32'h0, 8'h00, 8);
   endtask
endmodule

//--- verification/fes_ctrl_tb.sv
// self-checking bench for the erase and suspend controller
`timescale 1ns/1ps
module fes_ctrl_tb;
   localparam int PROG_CYC = 200;
   localparam int SERASE_CYC = 400;
   localparam int CERASE_CYC = 300;
   localparam int EVAL_CYC = 16;
   localparam int SUSP_CYC = 4;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic csn_i;
   logic sck_i;
   logic si_i;
   logic [31:0] rd_addr_i = 32'h0;
   logic rd_undefined_o;
   logic [7:0] status_one_o;
   logic [7:0] status_two_o;
   logic array_fill_ones_o;
   int err_count = 0;
   int tests_run = 0;
   int fill_cnt = 0;
   int cyc = 0;

   always #4 clk_i = ~clk_i;

   fes_ctrl #(.PROG_CYC(PROG_CYC), .SERASE_CYC(SERASE_CYC), .CERASE_CYC(CERASE_CYC), .EVAL_CYC(EVAL_CYC),
      .SUSP_CYC(SUSP_CYC)) uut (.clk_i(clk_i), .srst_i(srst_i), .csn_i(csn_i), .sck_i(sck_i), .si_i(si_i),
      .rd_addr_i(rd_addr_i), .rd_undefined_o(rd_undefined_o), .status_one_o(status_one_o),
      .status_two_o(status_two_o), .array_fill_ones_o(array_fill_ones_o));

   fes_host host (.clk_i(clk_i), .csn_o(csn_i), .sck_o(sck_i), .si_o(si_i));

   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      host.send(op, 32'h0, 8'h00, 8);
   endtask

   task automatic cmda(input logic [7:0] op, input logic [31:0] a);
      host.send(op, a, 8'h00, 40);
   endtask

   task automatic cmdd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
      host.send(op, a, d, 48);
   endtask

   // host polls busy under a bound
   task automatic wait_busy(input logic v, input int max);
      int n;
      n = 0;
      while (status_one_o[0] !== v && n < max) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(status_one_o[0], v, "busy wait");
   endtask

   task automatic chk_rd(input logic [31:0] a, input logic e);
      @(posedge clk_i);
      #1 rd_addr_i = a;
      @(posedge clk_i);
      #1 chk(rd_undefined_o, e, "read region");
   endtask

   function automatic logic [31:0] sect(input int s);
      return 32'(s) << 17;
   endfunction

   task automatic t_eval();
      cmda(fes_pkg::OPC_ERASE_STATUS_EVAL, sect(5));
      chk(status_one_o[0], 1'b1, "eval busy");
      wait_busy(1'b0, EVAL_CYC + 8);
      chk(status_two_o[2], 1'b0, "never erased");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmda(fes_pkg::OPC_SECTOR_ERASE, sect(5));
      wait_busy(1'b0, SERASE_CYC + 8);
      cmda(fes_pkg::OPC_ERASE_STATUS_EVAL, sect(5));
      wait_busy(1'b0, EVAL_CYC + 8);
      chk(status_two_o[2], 1'b1, "erased ok");
      cmda(fes_pkg::OPC_ERASE_STATUS_EVAL, 32'h0100_0000 | sect(5));
      wait_busy(1'b0, EVAL_CYC + 8);
      chk(status_one_o[5], 1'b0, "range fail flag");
   endtask

   task automatic t_chip();
      int f0;
      f0 = fill_cnt;
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmd(fes_pkg::OPC_WHOLE_ARRAY_ERASE);
      chk(status_one_o[0], 1'b1, "chip busy");
      cmd(fes_pkg::OPC_SUSPEND_A);
      wait_busy(1'b0, CERASE_CYC + 8);
      chk(array_fill_ones_o, 1'b1, "fill pulse");
      @(posedge clk_i);
      #1 chk(fill_cnt == f0 + 1, 1'b1, "one fill pulse");
      chk(status_two_o[1:0] === 2'h0, 1'b1, "chip not suspended");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmdd(fes_pkg::OPC_GENERIC_REG_WRITE, 32'h0, 8'h04);
      chk(status_one_o[4:2] === 3'h1, 1'b1, "protect set");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmd(fes_pkg::OPC_WHOLE_ARRAY_ERASE);
      chk(status_one_o[0], 1'b0, "protected chip");
      repeat (CERASE_CYC + 8) @(posedge clk_i);
      #1 chk(fill_cnt == f0 + 1, 1'b1, "no fill");
      chk(status_one_o[5], 1'b0, "no fail flag");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmda(fes_pkg::OPC_SECTOR_ERASE, sect(3));
      chk(status_one_o[5], 1'b1, "protected sector fail");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmdd(fes_pkg::OPC_GENERIC_REG_WRITE, 32'h0, 8'h00);
   endtask

   task automatic t_prog();
      logic lat;
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmdd(fes_pkg::OPC_PAGE_PROGRAM, 32'h0006_0400, 8'h5a);
      cmd(fes_pkg::OPC_SUSPEND_A);
      wait_busy(1'b0, SUSP_CYC + 8);
      chk(status_two_o[1:0] === 2'h1, 1'b1, "prog suspended");
      chk_rd(32'h0006_05ff, 1'b1);
      chk_rd(32'h0006_0600, 1'b0);
      lat = status_one_o[1];
      cmd(fes_pkg::OPC_WRITE_DISABLE);
      chk(status_one_o[1], lat, "wrdis refused");
      cmd(fes_pkg::OPC_SUSPEND_B);
      chk(status_two_o[0], 1'b1, "second suspend");
      cmd(fes_pkg::OPC_VOLATILE_WREN);
      cmdd(fes_pkg::OPC_PAGE_PROGRAM, sect(20), 8'h11);
      chk(status_one_o[0], 1'b0, "program refused");
      cmdd(fes_pkg::OPC_GENERIC_REG_WRITE, 32'h0, 8'h1c);
      chk(status_one_o[4:2] === 3'h0, 1'b1, "reg write refused");
      cmda(fes_pkg::OPC_SECTOR_ERASE, sect(10));
      chk(status_one_o[0], 1'b0, "erase refused");
      cmd(fes_pkg::OPC_CLEAR_FAIL_FLAGS);
      chk(status_one_o[5], 1'b0, "clear in suspend");
      cmd(fes_pkg::OPC_RESUME_B);
      chk(status_one_o[0], 1'b1, "prog resumed");
      cmd(fes_pkg::OPC_SUSPEND_A);
      chk(status_one_o[0], 1'b1, "no second suspend");
      wait_busy(1'b0, PROG_CYC + 8);
      chk(status_two_o[0], 1'b0, "prog done");
   endtask

   task automatic t_erase();
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmda(fes_pkg::OPC_SECTOR_ERASE, sect(7));
      cmd(fes_pkg::OPC_SUSPEND_B);
      wait_busy(1'b0, SUSP_CYC + 8);
      chk(status_two_o[1:0] === 2'h2, 1'b1, "erase suspended");
      chk_rd(sect(7) + 32'h100, 1'b1);
      chk_rd(sect(8), 1'b0);
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmd(fes_pkg::OPC_WHOLE_ARRAY_ERASE);
      chk(status_one_o[0], 1'b0, "chip in suspend");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmdd(fes_pkg::OPC_PAGE_PROGRAM, sect(8), 8'h33);
      chk(status_one_o[0], 1'b1, "prog in suspend");
      wait_busy(1'b0, PROG_CYC + 8);
      chk(status_two_o[1], 1'b1, "back to suspend");
      cmd(fes_pkg::OPC_RESUME_A);
      chk(status_one_o[0], 1'b1, "erase resumed");
      wait_busy(1'b0, SERASE_CYC + 8);
      chk(status_two_o[1], 1'b0, "erase done");
      cmd(fes_pkg::OPC_WRITE_ENABLE);
      cmda(fes_pkg::OPC_SECTOR_ERASE, sect(9));
      cmd(fes_pkg::OPC_SUSPEND_A);
      wait_busy(1'b0, SUSP_CYC + 8);
      host.reset_after_wait();
      chk(status_two_o[1], 1'b0, "reset clears");
   endtask

   task automatic t_idle();
      logic [7:0] s1;
      logic [7:0] s2;
      s1 = status_one_o;
      s2 = status_two_o;
      cmd(fes_pkg::OPC_SUSPEND_A);
      chk(status_one_o === s1 && status_two_o === s2, 1'b1, "idle suspend");
      cmd(fes_pkg::OPC_RESUME_B);
      chk(status_one_o[0], 1'b0, "idle resume");
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      #1 srst_i = 1'b0;
      repeat (4) @(posedge clk_i);
      t_eval();
      t_chip();
      t_prog();
      t_erase();
      t_idle();
      tally_and_finish();
   end

   // pulse counter and hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (array_fill_ones_o === 1'b1) begin
         fill_cnt <= fill_cnt + 1;
      end
      if (cyc == 30000) begin
         err_count++;
         tally_and_finish();
      end
   end
endmodule
